// *** iafc_pkg.sv ***
package iafc_pkg;

   // register index on the special function register port
   localparam int unsigned ADDR_W         = 4;
   localparam logic [3:0]  OFS_ADDR_LOW   = 4'h0;
   localparam logic [3:0]  OFS_ADDR_HIGH  = 4'h1;
   localparam logic [3:0]  OFS_PORT0_LOW  = 4'h2;
   localparam logic [3:0]  OFS_PORT0_HIGH = 4'h3;
   localparam logic [3:0]  OFS_PORT1_LOW  = 4'h4;
   localparam logic [3:0]  OFS_PORT1_HIGH = 4'h5;
   localparam logic [3:0]  OFS_PORT2_LOW  = 4'h6;
   localparam logic [3:0]  OFS_PORT2_HIGH = 4'h7;
   localparam logic [3:0]  OFS_PORT3_LOW  = 4'h8;
   localparam logic [3:0]  OFS_PORT3_HIGH = 4'h9;
   localparam logic [3:0]  OFS_OP_CTRL    = 4'hA;
   localparam logic [3:0]  OFS_RESET_KEY  = 4'hB;
   localparam logic [3:0]  OFS_TIMING     = 4'hC;

   // operation control field layout
   localparam int unsigned BIT_UNLOCKED   = 7;
   localparam int unsigned BIT_MODE_LSB   = 4;
   localparam int unsigned BIT_TRIGGER    = 3;
   localparam int unsigned BIT_PROG       = 2;
   localparam int unsigned BIT_PERMIT     = 1;
   localparam int unsigned BIT_READ       = 0;
   // timing and buffer control field layout
   localparam int unsigned BIT_DUR_SEL    = 1;
   localparam int unsigned BIT_BUF_CLEAR  = 0;

   localparam logic [7:0]  REG_RESET      = 8'h00;
   localparam logic [14:0] ADDR_RESET     = 15'h0000;

   localparam logic [2:0]  MODE_WRITE     = 3'h0;
   localparam logic [2:0]  MODE_ERASE     = 3'h1;
   localparam logic [2:0]  MODE_READ      = 3'h3;
   localparam logic [2:0]  MODE_UNLOCK    = 3'h6;

   localparam logic [7:0]  KEY_P1_LOW     = 8'h00;
   localparam logic [7:0]  KEY_P2_LOW     = 8'h0D;
   localparam logic [7:0]  KEY_P3_LOW     = 8'hC3;
   localparam logic [7:0]  KEY_P1_HIGH    = 8'h04;
   localparam logic [7:0]  KEY_P2_HIGH    = 8'h09;
   localparam logic [7:0]  KEY_P3_HIGH    = 8'h40;
   localparam logic [7:0]  CHIP_RESET_KEY = 8'h55;

   localparam int unsigned PAGE_LSB       = 6;
   localparam logic [5:0]  PAGE_LAST      = 6'h3F;

   // timing, in nanoseconds as printed, and the clock
   localparam int unsigned CLK_PERIOD_NS  = 20;
   localparam int unsigned ERASE0_NS      = 3200000;
   localparam int unsigned WRITE0_NS      = 2200000;
   localparam int unsigned ERASE1_NS      = 3700000;
   localparam int unsigned WRITE1_NS      = 3000000;
   localparam int unsigned UNLOCK_NS      = 20000;
   localparam int unsigned UNLOCK_CYC     = UNLOCK_NS / CLK_PERIOD_NS;
   localparam int unsigned CNT_W          = 18;

   typedef enum logic [1:0] {ST_IDLE, ST_UNLOCK, ST_PROG, ST_READ} iafc_state_e;

endpackage : iafc_pkg

// *** iafc_ctrl.sv ***
// Functional notes
// RULE1: unlocked flag set only by hardware; software write one ignored, zero locks.
// RULE2: mode 000 write, 001 erase, 011 read, 110 unlock; others reserved.
// RULE3: erase and write refused while unlocked flag is clear.
// RULE4: unlock trigger starts procedure timer, self-clears when timer expires.
// RULE5: software writes key into ports 1 to 3 before timer expiry.
// RULE6: program start launches erase or write, self-clears at finish (busy).
// RULE7: reads require read permit high; blocked while it is zero.
// RULE8: read start launches flash read, self-clears when read completes.
// RULE9: software never sets program start, permit and read start together.
// RULE10: processor stalled during read, write or erase, released afterwards.
// RULE11: writing 55H to chip reset key resets the whole chip.
// RULE12: duration select: erase 3.2ms/write 2.2ms, or 3.7ms/3.0ms.
// RULE13: buffer clear bit empties write buffer, self-clears when done.
// RULE14: port0 high writes tag erase addresses and advance the address.
// RULE15: address stops at page boundary, low six bits 111111b.
// RULE16: software blank-checks erased words for 0000h, erases again on mismatch.
// RULE17: on write mismatch software clears buffer and rewrites the page.
// RULE18: software clears unlocked flag when finished to relock flash.
// RULE19: port3 low and high bytes are read/write, reset to zero.
// RULE20: software ensures the sub clock is stable before erase or write.
// RULE21: software waits for completion before starting another operation.
// RULE22: upper six bits of timing control read as zero.
// RULE23: unlock key 00,0D,C3 low and 04,09,40 high bytes, exact only.
// RULE24: port0 high write loads 16-bit word into buffer, then increments address.
// RULE25: write buffer holds 64 words of the page named by address 14:6.
// RULE26: write buffer cleared automatically when a write finishes.
// RULE27: wrong key at timer expiry leaves unlocked flag at zero.
// RULE28: busy bits held for the selected duration counted in clock cycles.
`timescale 1ns/1ps
module iafc_ctrl
   import iafc_pkg::*;
#(
   parameter int unsigned CLK_PERIOD_NS_P = CLK_PERIOD_NS,
   parameter int unsigned ERASE0_CYC      = ERASE0_NS / CLK_PERIOD_NS_P,
   parameter int unsigned WRITE0_CYC      = WRITE0_NS / CLK_PERIOD_NS_P,
   parameter int unsigned ERASE1_CYC      = ERASE1_NS / CLK_PERIOD_NS_P,
   parameter int unsigned WRITE1_CYC      = WRITE1_NS / CLK_PERIOD_NS_P
)
(
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rstn_i,
   // special function register port
   input  wire logic [ADDR_W-1:0] sfr_addr_i,
   input  wire logic              sfr_wr_i,
   input  wire logic              sfr_rd_i,
   input  wire logic [7:0]        sfr_wdata_i,
   output logic      [7:0]        sfr_rdata_o,
   // system
   output logic                   cpu_stall_o,
   output logic                   chip_reset_o,
   // flash array side
   output logic                   fl_erase_o,
   output logic                   fl_write_o,
   output logic                   fl_read_o,
   output logic      [14:0]       fl_addr_o,
   output logic      [63:0]       fl_slot_mark_o,
   input  wire logic [5:0]        fl_buf_idx_i,
   output logic      [15:0]       fl_buf_data_o,
   input  wire logic              fl_read_done_i,
   input  wire logic [15:0]       fl_read_data_i
);

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs, input logic en);
      hit = en && (a == ofs);
   endfunction : hit

   iafc_state_e       state_reg;
   logic [CNT_W-1:0]  cnt_reg;
   logic              unlocked_reg;
   logic              unlocked_next;
   logic [2:0]        mode_reg;
   logic              permit_reg;
   logic              dur_sel_reg;
   logic              clear_reg;
   logic [7:0]        reset_key_reg;
   logic [14:0]       addr_reg;
   logic [14:0]       addr_next;
   logic [7:0]        dlo_reg [0:3];
   logic [7:0]        dhi_reg [0:3];
   logic [15:0]       wbuf_mem [0:63];
   logic [63:0]       mark_reg;
   logic [7:0]        rdata_reg;
   logic              chip_reset_reg;
   logic [15:0]       buf_out_reg;
   logic [7:0]        rd_mux;

   // register write decode
   wire               wr_op      = hit(sfr_addr_i, OFS_OP_CTRL, sfr_wr_i);
   wire               wr_key     = hit(sfr_addr_i, OFS_RESET_KEY, sfr_wr_i);
   wire               wr_timing  = hit(sfr_addr_i, OFS_TIMING, sfr_wr_i);
   wire               wr_alo     = hit(sfr_addr_i, OFS_ADDR_LOW, sfr_wr_i);
   wire               wr_ahi     = hit(sfr_addr_i, OFS_ADDR_HIGH, sfr_wr_i);
   wire               wr_word    = hit(sfr_addr_i, OFS_PORT0_HIGH, sfr_wr_i);
   wire [2:0]         wmode      = sfr_wdata_i[BIT_MODE_LSB +: 3];
   wire               idle       = (state_reg == ST_IDLE);

   // erase/write only once unlocked and in a program mode
   wire               prog_mode  = (wmode == MODE_WRITE) || (wmode == MODE_ERASE); // RULE2
   wire               start_prog = wr_op && sfr_wdata_i[BIT_PROG] && idle && unlocked_reg && prog_mode; // RULE3
   // program start takes priority if software breaks the single-write restriction
   wire               start_read = wr_op && sfr_wdata_i[BIT_READ] && permit_reg && (wmode == MODE_READ)
                                   && idle && !start_prog; // RULE7
   wire               start_unl  = wr_op && sfr_wdata_i[BIT_TRIGGER] && idle && (wmode == MODE_UNLOCK)
                                   && !start_prog && !start_read;
   wire               cnt_zero   = (cnt_reg == '0);

   wire               key_ok     = (dlo_reg[1] == KEY_P1_LOW) && (dlo_reg[2] == KEY_P2_LOW)
                                   && (dlo_reg[3] == KEY_P3_LOW) && (dhi_reg[1] == KEY_P1_HIGH)
                                   && (dhi_reg[2] == KEY_P2_HIGH) && (dhi_reg[3] == KEY_P3_HIGH); // RULE23
   wire               unlock_ok  = (state_reg == ST_UNLOCK) && cnt_zero && key_ok; // RULE27
   wire               prog_done  = (state_reg == ST_PROG) && cnt_zero;
   wire               read_done  = (state_reg == ST_READ) && fl_read_done_i;

   // duration chosen when the operation is launched
   wire [CNT_W-1:0]   erase_cyc  = dur_sel_reg ? CNT_W'(ERASE1_CYC - 1) : CNT_W'(ERASE0_CYC - 1); // RULE12
   wire [CNT_W-1:0]   write_cyc  = dur_sel_reg ? CNT_W'(WRITE1_CYC - 1) : CNT_W'(WRITE0_CYC - 1); // RULE12
   wire [CNT_W-1:0]   prog_cyc   = (wmode == MODE_ERASE) ? erase_cyc : write_cyc;

   // software may only clear; hardware set wins over a same-cycle clear
   always_comb
   begin
      unlocked_next = unlocked_reg;
      if (wr_op)
      begin
         unlocked_next = unlocked_reg & sfr_wdata_i[BIT_UNLOCKED]; // RULE1
      end
      if (unlock_ok)
      begin
         unlocked_next = 1'b1; // RULE1
      end
   end

   // page-bounded auto increment
   always_comb
   begin
      addr_next = addr_reg;
      if (wr_alo)
      begin
         addr_next = {addr_reg[14:8], sfr_wdata_i};
      end
      else if (wr_ahi)
      begin
         addr_next = {sfr_wdata_i[6:0], addr_reg[7:0]};
      end
      else if (wr_word && (addr_reg[PAGE_LSB-1:0] != PAGE_LAST))
      begin
         addr_next = addr_reg + 15'h0001; // RULE15
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state_reg <= ST_IDLE;
         cnt_reg   <= '0;
      end
      else
      begin
         unique case (state_reg)
            ST_IDLE:
            begin
               if (start_prog)
               begin
                  state_reg <= ST_PROG; // RULE6
                  cnt_reg   <= prog_cyc; // RULE28
               end
               else if (start_read)
               begin
                  state_reg <= ST_READ; // RULE8
               end
               else if (start_unl)
               begin
                  state_reg <= ST_UNLOCK; // RULE4
                  cnt_reg   <= CNT_W'(UNLOCK_CYC - 1);
               end
            end
            ST_UNLOCK, ST_PROG:
            begin
               if (cnt_zero)
               begin
                  state_reg <= ST_IDLE; // RULE4
               end
               else
               begin
                  cnt_reg <= cnt_reg - 1'b1; // RULE28
               end
            end
            ST_READ:
            begin
               if (fl_read_done_i)
               begin
                  state_reg <= ST_IDLE; // RULE8
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         unlocked_reg <= 1'b0;
         mode_reg     <= 3'h0;
         permit_reg   <= 1'b0;
         dur_sel_reg  <= 1'b0;
         clear_reg    <= 1'b0;
         reset_key_reg <= REG_RESET;
         addr_reg     <= ADDR_RESET;
      end
      else
      begin
         unlocked_reg <= unlocked_next;
         addr_reg     <= addr_next;
         if (wr_op)
         begin
            mode_reg   <= wmode;
            permit_reg <= sfr_wdata_i[BIT_PERMIT];
         end
         if (wr_key)
         begin
            reset_key_reg <= sfr_wdata_i;
         end
         if (wr_timing)
         begin
            dur_sel_reg <= sfr_wdata_i[BIT_DUR_SEL];
         end
         // clearing takes the one cycle the flag is seen high
         clear_reg <= wr_timing && sfr_wdata_i[BIT_BUF_CLEAR]; // RULE13
      end
   end

   // data port bytes; port0 also receives read results
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         for (int i = 0; i < 4; i++)
         begin
            dlo_reg[i] <= REG_RESET; // RULE19
            dhi_reg[i] <= REG_RESET; // RULE19
         end
      end
      else if (read_done)
      begin
         dlo_reg[0] <= fl_read_data_i[7:0];
         dhi_reg[0] <= fl_read_data_i[15:8];
      end
      else if (sfr_wr_i && (sfr_addr_i >= OFS_PORT0_LOW) && (sfr_addr_i <= OFS_PORT3_HIGH))
      begin
         if (sfr_addr_i[0])
         begin
            dhi_reg[sfr_addr_i[2:1] - 2'h1] <= sfr_wdata_i;
         end
         else
         begin
            dlo_reg[sfr_addr_i[2:1] - 2'h1] <= sfr_wdata_i;
         end
      end
   end

   // buffer contents need no reset; the mark vector says which slots hold data
   always_ff @(posedge clk_i)
   begin
      if (wr_word)
      begin
         wbuf_mem[addr_reg[PAGE_LSB-1:0]] <= {sfr_wdata_i, dlo_reg[0]}; // RULE24
      end
      buf_out_reg <= mark_reg[fl_buf_idx_i] ? wbuf_mem[fl_buf_idx_i] : 16'h0000; // RULE25
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         mark_reg <= 64'h0000000000000000;
      end
      else if (clear_reg || prog_done)
      begin
         mark_reg <= 64'h0000000000000000; // RULE26
      end
      else if (wr_word)
      begin
         mark_reg[addr_reg[PAGE_LSB-1:0]] <= 1'b1; // RULE14
      end
   end

   // register read mux, reserved bits zero
   always_comb
   begin
      unique case (sfr_addr_i)
         OFS_ADDR_LOW:   rd_mux = addr_reg[7:0];
         OFS_ADDR_HIGH:  rd_mux = {1'b0, addr_reg[14:8]};
         OFS_PORT0_LOW:  rd_mux = dlo_reg[0];
         OFS_PORT0_HIGH: rd_mux = dhi_reg[0];
         OFS_PORT1_LOW:  rd_mux = dlo_reg[1];
         OFS_PORT1_HIGH: rd_mux = dhi_reg[1];
         OFS_PORT2_LOW:  rd_mux = dlo_reg[2];
         OFS_PORT2_HIGH: rd_mux = dhi_reg[2];
         OFS_PORT3_LOW:  rd_mux = dlo_reg[3];
         OFS_PORT3_HIGH: rd_mux = dhi_reg[3];
         OFS_OP_CTRL:    rd_mux = {unlocked_reg, mode_reg, state_reg == ST_UNLOCK,
                                   state_reg == ST_PROG, permit_reg, state_reg == ST_READ}; // RULE6
         OFS_RESET_KEY:  rd_mux = reset_key_reg;
         OFS_TIMING:     rd_mux = {6'h00, dur_sel_reg, clear_reg}; // RULE22
         default:        rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rdata_reg      <= REG_RESET;
         chip_reset_reg <= 1'b0;
      end
      else
      begin
         if (sfr_rd_i)
         begin
            rdata_reg <= rd_mux;
         end
         chip_reset_reg <= wr_key && (sfr_wdata_i == CHIP_RESET_KEY); // RULE11
      end
   end

   assign sfr_rdata_o    = rdata_reg;
   assign chip_reset_o   = chip_reset_reg;
   assign cpu_stall_o    = (state_reg == ST_PROG) || (state_reg == ST_READ); // RULE10
   assign fl_erase_o     = (state_reg == ST_PROG) && (mode_reg == MODE_ERASE); // RULE6
   assign fl_write_o     = (state_reg == ST_PROG) && (mode_reg == MODE_WRITE); // RULE6
   assign fl_read_o      = (state_reg == ST_READ) && permit_reg; // RULE7
   assign fl_addr_o      = addr_reg;
   assign fl_slot_mark_o = mark_reg;
   assign fl_buf_data_o  = buf_out_reg;

endmodule : iafc_ctrl

// *** iafc_flash_model.sv ***
`timescale 1ns/1ps
module iafc_flash_model
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // pace and controller side
   input  wire logic        slow_i,
   input  wire logic        fl_read_o,
   input  wire logic [14:0] fl_addr_o,
   output logic             fl_read_done_i,
   output logic [15:0]      fl_read_data_i
);
   logic [3:0] wait_reg;
   logic       go;
   assign go = fl_read_o && !fl_read_done_i;
   // bus toggles outside the done pulse so stale data never matches
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
      begin
         wait_reg       <= 4'h0;
         fl_read_done_i <= 1'b0;
         fl_read_data_i <= 16'hFFFF;
      end
      else if (go && wait_reg == (slow_i ? 4'h6 : 4'h1))
      begin
         fl_read_done_i <= 1'b1;
         fl_read_data_i <= {1'b1, fl_addr_o};
      end
      else
      begin
         wait_reg       <= go ? wait_reg + 4'h1 : 4'h0;
         fl_read_done_i <= 1'b0;
         fl_read_data_i <= ~fl_read_data_i;
      end
endmodule : iafc_flash_model

// *** iafc_ctrl_checker.sv ***
`timescale 1ns/1ps
module iafc_ctrl_checker
   import iafc_pkg::*;
#(
   parameter int unsigned ERASE0_CYC = 20,
   parameter int unsigned WRITE0_CYC = 10,
   parameter int unsigned ERASE1_CYC = 30,
   parameter int unsigned WRITE1_CYC = 15
)
(
   // clock, reset, register port
   input wire logic              clk_i,
   input wire logic              rstn_i,
   input wire logic [ADDR_W-1:0] sfr_addr_i,
   input wire logic              sfr_wr_i,
   input wire logic              sfr_rd_i,
   input wire logic [7:0]        sfr_wdata_i,
   input wire logic [7:0]        sfr_rdata_o,
   // system and flash side
   input wire logic              cpu_stall_o,
   input wire logic              chip_reset_o,
   input wire logic              fl_erase_o,
   input wire logic              fl_write_o,
   input wire logic              fl_read_o,
   input wire logic [14:0]       fl_addr_o,
   input wire logic [63:0]       fl_slot_mark_o,
   input wire logic              fl_read_done_i
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   logic [CNT_W-1:0] cnt_reg;
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         cnt_reg <= '0;
      else
         cnt_reg <= (fl_erase_o | fl_write_o) ? cnt_reg + 1'b1 : '0;
   sequence s_key_wr;
      sfr_wr_i && sfr_addr_i == OFS_RESET_KEY && sfr_wdata_i == CHIP_RESET_KEY;
   endsequence
   sequence s_hi_wr;
      sfr_wr_i && sfr_addr_i == OFS_PORT0_HIGH;
   endsequence
   chk_reset_pulse: assert property (s_key_wr |=> chip_reset_o ##1 !chip_reset_o)
      else $error("reset key gave no single pulse");
   chk_reset_other: assert property (sfr_wr_i && sfr_addr_i == OFS_RESET_KEY
      && sfr_wdata_i != CHIP_RESET_KEY |=> !chip_reset_o)
      else $error("chip reset from other value");
   chk_addr_step: assert property (s_hi_wr ##0 fl_addr_o[5:0] != PAGE_LAST
      |=> fl_addr_o == $past(fl_addr_o) + 15'h1)
      else $error("address not advanced");
   chk_addr_hold: assert property (s_hi_wr ##0 fl_addr_o[5:0] == PAGE_LAST |=> $stable(fl_addr_o))
      else $error("address left the page");
   chk_stall_busy: assert property (fl_erase_o || fl_write_o || fl_read_o |-> cpu_stall_o)
      else $error("operation without stall");
   chk_mode_excl: assert property (!(fl_erase_o && fl_write_o))
      else $error("erase and write together");
   chk_erase_len: assert property ($fell(fl_erase_o) |-> cnt_reg == ERASE0_CYC || cnt_reg == ERASE1_CYC)
      else $error("erase length wrong");
   chk_write_len: assert property ($fell(fl_write_o) |-> cnt_reg == WRITE0_CYC || cnt_reg == WRITE1_CYC)
      else $error("write length wrong");
   chk_marks_clear: assert property ($fell(fl_write_o) |-> fl_slot_mark_o == 64'h0)
      else $error("buffer not cleared after write");
   chk_read_end: assert property (fl_read_o && fl_read_done_i |-> ##[1:2] !fl_read_o && !cpu_stall_o)
      else $error("read did not end");
   chk_upper_zero: assert property (sfr_rd_i && sfr_addr_i == OFS_TIMING |=> sfr_rdata_o[7:2] == 6'h00)
      else $error("timing upper bits set");
endmodule : iafc_ctrl_checker
bind iafc_ctrl iafc_ctrl_checker #(.ERASE0_CYC(ERASE0_CYC), .WRITE0_CYC(WRITE0_CYC), .ERASE1_CYC(ERASE1_CYC),
   .WRITE1_CYC(WRITE1_CYC)) u_iafc_ctrl_checker (.clk_i, .rstn_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i,
   .sfr_wdata_i, .sfr_rdata_o, .cpu_stall_o, .chip_reset_o, .fl_erase_o, .fl_write_o, .fl_read_o,
   .fl_addr_o, .fl_slot_mark_o, .fl_read_done_i);

// *** iafc_ctrl_tb.sv ***
`timescale 1ns/1ps
module iafc_ctrl_tb
   import iafc_pkg::*;
();
   `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
   localparam int E0 = 20, W0 = 10, E1 = 30, W1 = 15;
   typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] e;} iafc_row_s;
   iafc_row_s rows [9] = '{'{4'h8, 8'hA5, 8'hA5}, '{4'h9, 8'h5A, 8'h5A}, '{4'hB, 8'hAA, 8'hAA},
      '{4'hC, 8'hFE, 8'h02}, '{4'hA, 8'h80, 8'h00}, '{4'hD, 8'hFF, 8'h00}, '{4'hA, 8'h14, 8'h10},
      '{4'hA, 8'h08, 8'h00}, '{4'hA, 8'h21, 8'h20}};
   logic [7:0] key [6] = '{KEY_P1_LOW, KEY_P1_HIGH, KEY_P2_LOW, KEY_P2_HIGH, KEY_P3_LOW, KEY_P3_HIGH};
   int durs [4] = '{E0, W0, E1, W1};
   logic              clk_i = 1'b0;
   logic              rstn_i = 1'b0;
   logic [ADDR_W-1:0] sfr_addr_i = 4'h0;
   logic              sfr_wr_i = 1'b0;
   logic              sfr_rd_i = 1'b0;
   logic [7:0]        sfr_wdata_i = 8'h00;
   logic [5:0]        fl_buf_idx_i = 6'h00;
   logic              slow_i = 1'b0;
   logic [7:0]        sfr_rdata_o;
   logic              cpu_stall_o, chip_reset_o, fl_erase_o, fl_write_o, fl_read_o, fl_read_done_i;
   logic [14:0]       fl_addr_o;
   logic [63:0]       fl_slot_mark_o;
   logic [15:0]       fl_buf_data_o, fl_read_data_i;
   int                err_count = 0, checks_done = 0, cyc = 0, n;
   iafc_ctrl #(.ERASE0_CYC(E0), .WRITE0_CYC(W0), .ERASE1_CYC(E1), .WRITE1_CYC(W1)) u_iafc_ctrl (.clk_i,
      .rstn_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .cpu_stall_o, .chip_reset_o,
      .fl_erase_o, .fl_write_o, .fl_read_o, .fl_addr_o, .fl_slot_mark_o, .fl_buf_idx_i, .fl_buf_data_o,
      .fl_read_done_i, .fl_read_data_i);
   iafc_flash_model u_iafc_flash_model (.clk_i, .rstn_i, .slow_i, .fl_read_o, .fl_addr_o, .fl_read_done_i,
      .fl_read_data_i);
   initial
   begin
      forever #10 clk_i = ~clk_i;
   end
   task automatic test_done;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         err_count++;
         test_done();
      end
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      sfr_addr_i  <= a;
      sfr_wdata_i <= d;
      sfr_wr_i    <= 1'b1;
      @(posedge clk_i);
      sfr_wr_i    <= 1'b0;
      #1;
   endtask : wr
   task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_i);
      sfr_addr_i <= a;
      sfr_rd_i   <= 1'b1;
      @(posedge clk_i);
      sfr_rd_i   <= 1'b0;
      #1;
      `CHK(sfr_rdata_o, e)
   endtask : rdchk
   // bounded wait so a stuck busy bit cannot hang the run
   task automatic op(input logic [7:0] ctl);
      wr(OFS_OP_CTRL, ctl);
      n = 0;
      while (cpu_stall_o === 1'b1 && n < 400)
      begin
         @(posedge clk_i);
         #1;
         n++;
      end
   endtask : op
   initial
   begin
      repeat (20) @(posedge clk_i);
      rstn_i <= 1'b1;
      for (int i = 0; i <= 13; i++) rdchk(4'(i), 8'h00);
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].d);
         rdchk(rows[i].a, rows[i].e);
      end
      wr(OFS_OP_CTRL, 8'h68);
      rdchk(OFS_OP_CTRL, 8'h68);
      repeat (UNLOCK_CYC) @(posedge clk_i);
      rdchk(OFS_OP_CTRL, 8'h60);
      wr(OFS_OP_CTRL, 8'h68);
      foreach (key[i]) wr(4'(4 + i), key[i]);
      repeat (UNLOCK_CYC) @(posedge clk_i);
      rdchk(OFS_OP_CTRL, 8'hE0);
      wr(OFS_ADDR_LOW, 8'h3E);
      wr(OFS_ADDR_HIGH, 8'h00);
      wr(OFS_PORT0_LOW, 8'h34);
      wr(OFS_PORT0_HIGH, 8'h12);
      `CHK(fl_addr_o, 15'h003F)
      wr(OFS_PORT0_HIGH, 8'h56);
      `CHK(fl_addr_o, 15'h003F)
      `CHK(fl_slot_mark_o[63:62], 2'b11)
      @(posedge clk_i);
      fl_buf_idx_i <= 6'h3E;
      repeat (2) @(posedge clk_i);
      #1;
      `CHK(fl_buf_data_o, 16'h1234)
      for (int k = 0; k < 4; k++)
      begin
         wr(OFS_TIMING, {6'h00, k[1], 1'b0});
         wr(OFS_PORT0_HIGH, 8'h77);
         op(k[0] ? 8'h84 : 8'h94);
         `CHK(n, durs[k])
         rdchk(OFS_OP_CTRL, k[0] ? 8'h80 : 8'h90);
         `CHK(fl_slot_mark_o, 64'h0)
      end
      wr(OFS_PORT0_HIGH, 8'h01);
      wr(OFS_TIMING, 8'h01);
      rdchk(OFS_TIMING, 8'h00);
      `CHK(fl_slot_mark_o, 64'h0)
      wr(OFS_OP_CTRL, 8'h02);
      rdchk(OFS_OP_CTRL, 8'h02);
      op(8'h94);
      rdchk(OFS_OP_CTRL, 8'h10);
      op(8'h33);
      rdchk(OFS_OP_CTRL, 8'h32);
      for (int s = 0; s < 2; s++)
      begin
         wr(OFS_ADDR_LOW, 8'(8'h21 + s));
         wr(OFS_ADDR_HIGH, 8'h12);
         slow_i <= s[0];
         wr(OFS_OP_CTRL, 8'h33);
         `CHK(cpu_stall_o, 1'b1)
         op(8'h32);
         rdchk(OFS_PORT0_LOW, 8'(8'h21 + s));
         rdchk(OFS_PORT0_HIGH, 8'h92);
      end
      // second reset mid-run, registers must return to zero
      @(posedge clk_i);
      rstn_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rstn_i <= 1'b1;
      rdchk(OFS_PORT3_HIGH, 8'h00);
      rdchk(OFS_OP_CTRL, 8'h00);
      wr(OFS_RESET_KEY, CHIP_RESET_KEY);
      `CHK(chip_reset_o, 1'b1)
      test_done();
   end
endmodule : iafc_ctrl_tb
